// ### verilog/edo_ctl_pkg.sv
// Shared constants and state type for the page-mode DRAM controller
package edo_ctl_pkg;
    // Clock and pin widths
    localparam int CLK_PERIOD_NS = 50;
    localparam int ROW_W = 10;
    localparam int COL_W = 10;
    localparam int DATA_W = 16;
    localparam int HOST_ADDR_W = ROW_W + COL_W;
    // Power-up pause, a least time, rounded up
    localparam int PAUSE_US = 200;
    localparam int PAUSE_CYCLES = (PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAUSE_CNT_W = 12;
    // Wake-up row strobe cycles
    localparam int WAKE_CYCLES = 8;
    localparam int WAKE_CNT_W = 4;
    // Refresh period and rows, spacing rounded down
    localparam int TREF_MS = 16;
    localparam int REFRESH_ROWS = 1024;
    localparam int REFRESH_GAP_NS = (TREF_MS * 1000000) / REFRESH_ROWS;
    localparam int REFRESH_GAP_CYCLES = REFRESH_GAP_NS / CLK_PERIOD_NS;
    localparam int GAP_CNT_W = 9;
    localparam int TREF_CYCLES_DEF = (TREF_MS * 1000000) / CLK_PERIOD_NS;
    // Pin reset values
    localparam logic [ROW_W-1:0] ADDR_RESET = 10'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

    // Controller sequence states
    typedef enum logic [3:0] {
        ST_PAUSE = 4'h0,
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_ROW = 4'h3,
        ST_COL = 4'h4,
        ST_CAS = 4'h5,
        ST_CASH = 4'h6,
        ST_PRE = 4'h7,
        ST_REF_STROBE = 4'h8,
        ST_REF_ROW = 4'h9,
        ST_REF_HOLD = 4'ha
    } state_t;
endpackage

// ### verilog/init_link_if.sv
// Carrier between the access sequencer and the wake-up and refresh timer
`timescale 1ns/10ps
interface init_link_if;
    logic refresh_done; // One-cycle pulse: a row-strobe refresh cycle finished
    logic pause_done; // Level: power-up pause elapsed
    logic wake_done; // Level: enough wake-up cycles seen
    logic refresh_due; // Level: a distributed refresh is owed

    modport sequencer (
        output refresh_done,
        input pause_done,
        input wake_done,
        input refresh_due
    );

    modport timer (
        input refresh_done,
        output pause_done,
        output wake_done,
        output refresh_due
    );
endinterface

// ### verilog/init_refresh_timer.sv
// Power-up pause, wake-up count, refresh spacing and refresh-age watchdog
`timescale 1ns/10ps
module init_refresh_timer #(
    parameter int TREF_CYCLES = edo_ctl_pkg::TREF_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    init_link_if.timer link
);
    localparam int AGE_W = $clog2(TREF_CYCLES + 1);

    logic [edo_ctl_pkg::PAUSE_CNT_W-1:0] pause_cnt; // Cycles since reset
    logic [edo_ctl_pkg::WAKE_CNT_W-1:0] wake_cnt; // Wake cycles seen, saturating
    logic [edo_ctl_pkg::GAP_CNT_W-1:0] gap_cnt; // Cycles since last refresh slot
    logic [AGE_W-1:0] age_cnt; // Cycles since the last refresh
    logic pause_flag;
    logic due_flag;

    // Terminal counts
    wire pause_end = pause_cnt ==
        edo_ctl_pkg::PAUSE_CNT_W'(edo_ctl_pkg::PAUSE_CYCLES - 1);
    wire gap_end = gap_cnt ==
        edo_ctl_pkg::GAP_CNT_W'(edo_ctl_pkg::REFRESH_GAP_CYCLES - 1);
    wire age_end = age_cnt == AGE_W'(TREF_CYCLES - 1);
    wire wake_full = wake_cnt == edo_ctl_pkg::WAKE_CNT_W'(edo_ctl_pkg::WAKE_CYCLES);

    assign link.pause_done = pause_flag;
    assign link.refresh_due = due_flag;
    assign link.wake_done = wake_full;

    // Power-up pause counted from our own clock
    always_ff @(posedge mclk) begin
        if (rst) begin
            pause_cnt <= '0;
            pause_flag <= 1'b0;
        end else if (!pause_flag) begin
            pause_cnt <= pause_cnt + 1'b1; // (R5) (R14)
            pause_flag <= pause_end; // (R5)
        end
    end

    // Wake-up cycle count; a stale refresh restarts it
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_cnt <= '0;
        end else if (link.refresh_done) begin
            // Completion wins over the watchdog in the same cycle
            if (!wake_full) begin
                wake_cnt <= wake_cnt + 1'b1; // (R5) (R6)
            end
        end else if (age_end) begin
            wake_cnt <= '0; // (R7)
        end
    end

    // Distributed refresh spacing; a finished refresh clears the request
    always_ff @(posedge mclk) begin
        if (rst) begin
            gap_cnt <= '0;
            due_flag <= 1'b0;
        end else if (link.refresh_done) begin
            gap_cnt <= '0;
            // A slot ending in the same cycle still wins over the clear
            due_flag <= pause_flag && gap_end;
        end else if (pause_flag) begin
            if (gap_end) begin
                gap_cnt <= '0;
                due_flag <= 1'b1;
            end else begin
                gap_cnt <= gap_cnt + 1'b1;
            end
        end
    end

    // Refresh age watchdog, parks at its end until a refresh arrives
    always_ff @(posedge mclk) begin
        if (rst || link.refresh_done) begin
            age_cnt <= '0;
        end else if (pause_flag && !age_end) begin
            age_cnt <= age_cnt + 1'b1; // (R7)
        end
    end
endmodule // init_refresh_timer

// ### verilog/edo_page_ctl.sv
// Host-side controller driving an asynchronous page-mode 1M x 16 DRAM
`timescale 1ns/10ps
// Operation
// (R1) Any of 1,024 columns reachable in open page
// (R2) Read data held until next column strobe falls
// (R3) Reads and writes may mix in one page
// (R4) Short column cycles allowed thanks to held data
// (R5) Wait 200 us, then eight row cycles
// (R6) Wake cycles are column-before-row refreshes
// (R7) Stale refresh period repeats the wake sequence
// (R8) Row strobe held high during power-up
// (R9) Counter refresh uses the internal row counter
// (R10) Row then column on shared address lines
// (R11) Low strobe gates low byte, high strobe high
// (R12) Column strobe low before row strobe: refresh
// (R13) Page cycles: new column, no new row
// (R14) Own timer blocks host until init done
module edo_page_ctl #(
    parameter int TREF_CYCLES = edo_ctl_pkg::TREF_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [edo_ctl_pkg::HOST_ADDR_W-1:0] req_addr,
    input wire logic [edo_ctl_pkg::DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_be,
    output logic req_ready,
    output logic rsp_valid,
    output logic [edo_ctl_pkg::DATA_W-1:0] rsp_rdata,
    output logic init_done,
    output logic ras_n,
    output logic low_byte_column_strobe_n,
    output logic high_byte_column_strobe_n,
    output logic we_n,
    output logic oe_n,
    output logic [edo_ctl_pkg::COL_W-1:0] addr,
    output logic [edo_ctl_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [edo_ctl_pkg::DATA_W-1:0] dq_in
);

    init_link_if link ();

    edo_ctl_pkg::state_t state; // Current sequence step
    edo_ctl_pkg::state_t next_state; // Step for the next cycle

    // Latched access under way
    logic [edo_ctl_pkg::ROW_W-1:0] cur_row;
    logic [edo_ctl_pkg::COL_W-1:0] cur_col;
    logic cur_write;
    logic [1:0] cur_be;
    logic [edo_ctl_pkg::DATA_W-1:0] cur_wdata;

    init_refresh_timer #(
        .TREF_CYCLES(TREF_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .rst(rst),
        .link(link.timer)
    );

    // Request decode; a page hit only needs the same open row
    wire [edo_ctl_pkg::ROW_W-1:0] req_row =
        req_addr[edo_ctl_pkg::HOST_ADDR_W-1:edo_ctl_pkg::COL_W];
    wire [edo_ctl_pkg::COL_W-1:0] req_col = req_addr[edo_ctl_pkg::COL_W-1:0];
    wire in_idle = state == edo_ctl_pkg::ST_IDLE;
    wire in_cas = state == edo_ctl_pkg::ST_CAS;
    wire same_row = req_row == cur_row; // (R1) (R13)
    wire take = req_valid && req_ready && (in_idle || (in_cas && same_row));
    wire need_refresh = !link.wake_done || link.refresh_due; // (R5) (R7)

    // One pulse per finished row-strobe refresh cycle
    assign link.refresh_done = state == edo_ctl_pkg::ST_REF_HOLD; // (R6)

    // Values the pins will carry in the next cycle
    wire [edo_ctl_pkg::ROW_W-1:0] next_row = take ? req_row : cur_row;
    wire [edo_ctl_pkg::COL_W-1:0] next_col = take ? req_col : cur_col;
    wire next_write = take ? req_write : cur_write;
    wire [1:0] next_be = take ? req_be : cur_be;
    wire [edo_ctl_pkg::DATA_W-1:0] next_wdata = take ? req_wdata : cur_wdata;

    // Pin decode from the next state
    wire next_row_phase = next_state == edo_ctl_pkg::ST_ADDR ||
        next_state == edo_ctl_pkg::ST_ROW;
    wire next_row_open = next_state == edo_ctl_pkg::ST_ROW ||
        next_state == edo_ctl_pkg::ST_COL || next_state == edo_ctl_pkg::ST_CAS ||
        next_state == edo_ctl_pkg::ST_CASH || next_state == edo_ctl_pkg::ST_REF_ROW ||
        next_state == edo_ctl_pkg::ST_REF_HOLD;
    wire next_refresh = next_state == edo_ctl_pkg::ST_REF_STROBE ||
        next_state == edo_ctl_pkg::ST_REF_ROW || next_state == edo_ctl_pkg::ST_REF_HOLD;
    wire next_col_phase = next_state == edo_ctl_pkg::ST_COL ||
        next_state == edo_ctl_pkg::ST_CAS || next_state == edo_ctl_pkg::ST_CASH;
    wire next_strobe = next_state == edo_ctl_pkg::ST_CAS;
    wire next_ras_n = !next_row_open; // (R8)
    wire next_low_cas_n = !(next_refresh || (next_strobe && next_be[0])); // (R11) (R12)
    wire next_high_cas_n = !(next_refresh || (next_strobe && next_be[1])); // (R11) (R12)
    wire next_we_n = !(next_col_phase && next_write); // (R3)
    wire next_oe_n = !(next_col_phase && !next_write); // (R3) (R12)
    wire next_dq_oe = next_col_phase && next_write;
    // Row before column on the shared lines; refresh ignores them
    wire [edo_ctl_pkg::COL_W-1:0] next_addr = next_row_phase ? next_row : next_col; // (R10) (R9)
    // Ready only after init and with no refresh owed
    wire next_ready = link.wake_done && !link.refresh_due &&
        (next_state == edo_ctl_pkg::ST_IDLE || next_state == edo_ctl_pkg::ST_CAS); // (R14)
    // Read data masked to the strobed lanes
    wire [edo_ctl_pkg::DATA_W-1:0] lane_mask = {{8{cur_be[1]}}, {8{cur_be[0]}}}; // (R11)

    // Sequence step selection
    always_comb begin
        next_state = state;
        case (state)
            edo_ctl_pkg::ST_PAUSE: begin
                // Row strobe stays high while the pause runs
                if (link.pause_done) begin
                    next_state = edo_ctl_pkg::ST_IDLE; // (R5) (R8)
                end
            end
            edo_ctl_pkg::ST_IDLE: begin
                // An accepted access goes first, refresh waits one access
                if (take) begin
                    next_state = edo_ctl_pkg::ST_ADDR;
                end else if (need_refresh) begin
                    next_state = edo_ctl_pkg::ST_REF_STROBE; // (R6) (R7)
                end
            end
            edo_ctl_pkg::ST_ADDR: begin
                next_state = edo_ctl_pkg::ST_ROW; // (R10)
            end
            edo_ctl_pkg::ST_ROW: begin
                next_state = edo_ctl_pkg::ST_COL;
            end
            edo_ctl_pkg::ST_COL: begin
                next_state = edo_ctl_pkg::ST_CAS;
            end
            edo_ctl_pkg::ST_CAS: begin
                // Same-row request keeps the page open
                if (take) begin
                    next_state = edo_ctl_pkg::ST_CASH; // (R13) (R3)
                end else begin
                    next_state = edo_ctl_pkg::ST_PRE;
                end
            end
            edo_ctl_pkg::ST_CASH: begin
                // Two-cycle page step, short thanks to held read data
                next_state = edo_ctl_pkg::ST_CAS; // (R4) (R13)
            end
            edo_ctl_pkg::ST_PRE: begin
                next_state = edo_ctl_pkg::ST_IDLE;
            end
            edo_ctl_pkg::ST_REF_STROBE: begin
                next_state = edo_ctl_pkg::ST_REF_ROW; // (R12)
            end
            edo_ctl_pkg::ST_REF_ROW: begin
                next_state = edo_ctl_pkg::ST_REF_HOLD; // (R9)
            end
            edo_ctl_pkg::ST_REF_HOLD: begin
                next_state = edo_ctl_pkg::ST_PRE;
            end
            default: begin
                next_state = edo_ctl_pkg::ST_PAUSE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= edo_ctl_pkg::ST_PAUSE;
        end else begin
            state <= next_state;
        end
    end

    // Access latch, loaded only when a request is taken
    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_row <= edo_ctl_pkg::ADDR_RESET;
            cur_col <= edo_ctl_pkg::ADDR_RESET;
            cur_write <= 1'b0;
            cur_be <= 2'h0;
            cur_wdata <= edo_ctl_pkg::DATA_RESET;
        end else if (take) begin
            cur_row <= req_row;
            cur_col <= req_col;
            cur_write <= req_write;
            cur_be <= req_be;
            cur_wdata <= req_wdata;
        end
    end

    // DRAM pins, all registered; strobes idle high from reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            ras_n <= 1'b1; // (R8)
            low_byte_column_strobe_n <= 1'b1;
            high_byte_column_strobe_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            addr <= edo_ctl_pkg::ADDR_RESET;
            dq_out <= edo_ctl_pkg::DATA_RESET;
            dq_oe <= 1'b0;
        end else begin
            ras_n <= next_ras_n;
            low_byte_column_strobe_n <= next_low_cas_n;
            high_byte_column_strobe_n <= next_high_cas_n;
            we_n <= next_we_n;
            oe_n <= next_oe_n;
            addr <= next_addr;
            dq_out <= next_wdata;
            dq_oe <= next_dq_oe;
        end
    end

    // Host side: ready, init flag and read return
    always_ff @(posedge mclk) begin
        if (rst) begin
            req_ready <= 1'b0;
            init_done <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= edo_ctl_pkg::DATA_RESET;
        end else begin
            req_ready <= next_ready; // (R14)
            init_done <= link.wake_done;
            // Sampled as the strobe rises; held data makes this safe
            rsp_valid <= in_cas && !cur_write; // (R2)
            if (in_cas && !cur_write) begin
                rsp_rdata <= dq_in & lane_mask; // (R2) (R11)
            end
        end
    end
endmodule // edo_page_ctl

// ### tb/edo_dram_model.sv
// Behavioural page-mode DRAM answering the controller's pins
`timescale 1ns/10ps
module edo_dram_model #(
    parameter int DLY = 5 // Access delay in ns after the strobes fall
) (
    input wire logic ras_n,
    input wire logic low_byte_column_strobe_n,
    input wire logic high_byte_column_strobe_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [9:0] addr,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    output logic [15:0] dq_in
);
    logic [15:0] cells [int]; // Stored words, unwritten ones read as zero
    logic [9:0] row = 10'h000; // Row opened by the last activation
    logic [9:0] ref_row = 10'h000; // Internal refresh row counter
    int ref_cnt = 0; // Counter refresh cycles seen
    logic [15:0] hold = 16'h0000; // Word put out, kept across strobe rises
    logic [1:0] lanes = 2'h0; // Byte lanes driven by the memory
    wire cas_n = low_byte_column_strobe_n & high_byte_column_strobe_n; // First fall, last rise
    wire [1:0] gate = {~high_byte_column_strobe_n, ~low_byte_column_strobe_n};
    // Undriven lanes show the inverse so a stale copy never passes
    assign dq_in = dq_oe ? dq_out : {(lanes[1] && !oe_n) ? hold[15:8] : ~hold[15:8],
        (lanes[0] && !oe_n) ? hold[7:0] : ~hold[7:0]};
    // Activation: a strobe already low selects counter refresh
    always @(negedge ras_n) begin
        if (!cas_n) begin
            ref_row = ref_row + 10'h001;
            ref_cnt++;
            lanes = 2'h0;
        end else begin
            row = addr;
        end
    end
    // Row strobe rise ends the cycle and frees the bus
    always @(posedge ras_n) lanes = 2'h0;
    // Column strobe fall: any column of the open row, read or write
    always @(negedge cas_n) begin : column
        int k;
        logic [15:0] w;
        k = int'({row, addr});
        w = cells.exists(k) ? cells[k] : 16'h0000;
        if (!ras_n && !we_n) begin
            lanes = 2'h0;
            if (gate[0]) w[7:0] = dq_out[7:0];
            if (gate[1]) w[15:8] = dq_out[15:8];
            cells[k] = w;
        end else if (!ras_n) begin
            // Old word stays until the new one is ready
            #DLY;
            hold = w;
            lanes = gate;
        end
    end
endmodule // edo_dram_model

// ### tb/edo_ctl_checker.sv
// Pin-level assertions for the page-mode DRAM controller
`timescale 1ns/10ps
module edo_ctl_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [19:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic [1:0] req_be,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic init_done,
    input wire logic ras_n,
    input wire logic low_byte_column_strobe_n,
    input wire logic high_byte_column_strobe_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [9:0] addr,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire up = low_byte_column_strobe_n & high_byte_column_strobe_n; // Both strobes high
    wire idle_take = req_valid && req_ready && ras_n && up; // Taken from idle
    logic [19:0] t_addr; // Address of the last take
    logic [15:0] t_data; // Write data of the last take
    logic [1:0] t_be; // Lanes of the last take
    logic [12:0] age; // Cycles since reset, saturating
    logic [3:0] rows; // Row strobe falls before init is done
    // Same-row take in the strobe cycle keeps the page open
    wire page_take = req_valid && req_ready && !ras_n && !up && req_addr[19:10] == t_addr[19:10];
    // Note what each take carries; count cycles and wake activations
    always_ff @(posedge mclk) begin
        if (idle_take || page_take) begin
            t_addr <= req_addr;
            t_data <= req_wdata;
            t_be <= req_be;
        end
        if (rst) begin
            age <= 13'h0;
            rows <= 4'h0;
        end else begin
            age <= (age == 13'h1fff) ? age : age + 13'h1;
            rows <= init_done ? 4'h0 : rows + 4'($fell(ras_n) && rows != 4'hf);
        end
    end
    sequence open_s; // Activation that is not a refresh
        $fell(ras_n) && up;
    endsequence
    sequence col_s; // Column presented as the strobes fall
        $fell(up) && addr == t_addr[9:0];
    endsequence
    sequence page_s; // Strobes rise then fall, row kept open
        (!ras_n && up) ##1 (!ras_n && $fell(up));
    endsequence
    reset_pins_a: assert property ($fell(rst) |->
        ras_n && up && oe_n && !dq_oe && !init_done)
        else $error("pins not idle after reset");
    pause_ras_a: assert property (int'(age) < edo_ctl_pkg::PAUSE_CYCLES |-> ras_n)
        else $error("row strobe active during pause");
    host_block_a: assert property (!init_done |-> !req_ready)
        else $error("host taken before init");
    init_count_a: assert property ($rose(init_done) |-> rows >= 4'h8 && int'(age) > 4000)
        else $error("init done too early");
    wake_cbr_a: assert property (!init_done && $fell(ras_n) |-> !up)
        else $error("wake cycle not a counter refresh");
    row_col_a: assert property (open_s |-> addr == t_addr[19:10] ##2 col_s)
        else $error("row or column address wrong");
    byte_lane_a: assert property (!ras_n && $fell(up) |->
        {!high_byte_column_strobe_n, !low_byte_column_strobe_n} == t_be)
        else $error("strobe lanes differ from enables");
    write_data_a: assert property (!ras_n && $fell(up) && !we_n |->
        dq_oe && oe_n && dq_out == t_data)
        else $error("write data not driven");
    read_bus_a: assert property (!ras_n && $fell(up) && we_n |-> !oe_n && !dq_oe)
        else $error("read bus not released");
    cbr_quiet_a: assert property ($fell(ras_n) && !up |-> oe_n && !dq_oe)
        else $error("refresh with outputs on");
    page_hold_a: assert property (page_take |=> page_s)
        else $error("page access reopened row");
    read_answer_a: assert property ((idle_take || page_take) && !req_write |->
        ##[2:6] rsp_valid)
        else $error("read answer missing");
endmodule // edo_ctl_checker
bind edo_page_ctl edo_ctl_checker chk (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .init_done(init_done), .ras_n(ras_n),
    .low_byte_column_strobe_n(low_byte_column_strobe_n), .we_n(we_n), .oe_n(oe_n),
    .high_byte_column_strobe_n(high_byte_column_strobe_n), .addr(addr), .dq_out(dq_out),
    .dq_oe(dq_oe));

// ### tb/testbench.sv
// Self-checking bench for the page-mode DRAM controller
`timescale 1ns/10ps
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [19:0] req_addr = 20'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic [1:0] req_be = 2'h3;
    logic req_ready, rsp_valid, init_done, ras_n, lo_n, hi_n, we_n, oe_n, dq_oe;
    logic [9:0] addr;
    logic [15:0] rsp_rdata, dq_out, dq_in;
    logic [15:0] shadow [int]; // Expected memory contents
    logic [15:0] expq [$]; // Expected read results, oldest first
    logic [9:0] open_row = 10'h000; // Row of the last take from idle
    int errors = 0;
    int total_checks = 0;
    int seed = 8480;
    always #25 mclk = ~mclk;
    edo_page_ctl dut (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done), .ras_n(ras_n),
        .low_byte_column_strobe_n(lo_n), .high_byte_column_strobe_n(hi_n), .we_n(we_n),
        .oe_n(oe_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    edo_dram_model mem (.ras_n(ras_n), .low_byte_column_strobe_n(lo_n),
        .high_byte_column_strobe_n(hi_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    // Count a comparison, report a mismatch
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hold a request from a falling edge until the controller takes it
    task automatic issue(input logic wr, input logic [19:0] a, input logic [1:0] be);
        int n;
        logic [15:0] w;
        n = 0;
        @(negedge mclk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = 16'($random(seed));
        req_be = be;
        // A different row is only taken once the page has closed
        while (!(req_ready === 1'b1 && (ras_n === 1'b1 || a[19:10] == open_row)) && n < 100) begin
            @(negedge mclk);
            n++;
        end
        if (n == 100) begin
            errors++;
            tally_and_finish();
        end
        if (ras_n === 1'b1) open_row = a[19:10];
        w = shadow.exists(int'(a)) ? shadow[int'(a)] : 16'h0000;
        if (wr) begin
            if (be[0]) w[7:0] = req_wdata[7:0];
            if (be[1]) w[15:8] = req_wdata[15:8];
            shadow[int'(a)] = w;
        end else begin
            expq.push_back({be[1] ? w[15:8] : 8'h00, be[0] ? w[7:0] : 8'h00});
        end
    endtask
    // Reset, then wait for the pause and wake-up cycles to finish
    task automatic do_reset();
        int n;
        int r0;
        @(negedge mclk);
        req_valid = 1'b0;
        rst = 1'b1;
        repeat (20) @(negedge mclk);
        check({15'h0, req_ready}, 16'h0000);
        r0 = mem.ref_cnt;
        rst = 1'b0;
        n = 0;
        while (init_done !== 1'b1 && n < 6000) begin
            check({15'h0, ras_n !== 1'b0 || n >= 4000}, 16'h0001);
            @(negedge mclk);
            n++;
        end
        check({15'h0, init_done}, 16'h0001);
        check(16'(n > 4000), 16'h0001);
        check(16'(mem.ref_cnt - r0 >= 8), 16'h0001);
        check(16'(mem.ref_row == 10'(mem.ref_cnt)), 16'h0001);
    endtask
    // Every read answer is compared with the oldest expectation
    always @(negedge mclk) begin
        if (rsp_valid === 1'b1) begin
            if (expq.size() != 0) check(rsp_rdata, expq.pop_front());
            else check(rsp_rdata, 16'hxxxx);
        end
    end
    // Cut a hang short
    initial begin
        #(20000 * 50);
        errors++;
        tally_and_finish();
    end
    initial begin
        do_reset();
        // Page writes up to the last column, then page reads back
        for (int i = 0; i < 4; i++) issue(1'b1, {10'h005, 10'(i * 341)}, 2'h3);
        for (int i = 0; i < 4; i++) issue(1'b0, {10'h005, 10'(i * 341)}, 2'h3);
        // Reads and writes mixed within one open row
        for (int i = 0; i < 10; i++) issue(i[0], {10'h2a7, 10'($random(seed) & 3)}, 2'h3);
        // Byte lanes written separately, read whole and per lane
        for (int i = 0; i < 6; i++) issue(i < 2, {10'h3ff, 10'h010}, 2'(i % 3 + 1));
        // Random rows, columns and lanes; two reads then two writes in turn
        for (int i = 0; i < 12; i++) begin
            issue(i[1], {10'({$random(seed)} % 4), 10'({$random(seed)} % 4)},
                2'({$random(seed)} % 3 + 1));
        end
        @(negedge mclk);
        req_valid = 1'b0;
        repeat (40) @(negedge mclk);
        // Reset in mid-run: contents survive, init repeats
        do_reset();
        issue(1'b0, {10'h005, 10'h3ff}, 2'h3);
        @(negedge mclk);
        req_valid = 1'b0;
        repeat (40) @(negedge mclk);
        check(16'(expq.size()), 16'h0000);
        tally_and_finish();
    end
endmodule // testbench
